/* File: tccr_chk.sv */
// checker: bus and event assertions on the compare/capture block
`default_nettype none
module tccr_chk (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic [15:0] COUNTER_VALUE,
  input wire logic [15:0] COUNTER_TOP,
  input wire logic        COMPARE_IRQ_C,
  input wire logic        CAPTURE_IRQ,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  // one timer clock, reset masks everything
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // both write halves taken at one edge
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // read answer offered, not yet taken
  sequence s_rd_wait;
    S_AXI_RVALID && !S_AXI_RREADY;
  endsequence
  property p_wr_lat;
    s_wr_taken |=> !S_AXI_BVALID ##[1:2] S_AXI_BVALID;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  // no second write accepted while one is answered
  property p_one_wr;
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
  endproperty
  a_one_wr: assert property (p_one_wr) else $error("write overlap");
  property p_rd_lat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> ##[0:1] S_AXI_RVALID;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_hold;
    s_rd_wait |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  // capture only loads the counter, or a bus write
  property p_cap_load;
    $changed(COUNTER_TOP) |-> COUNTER_TOP == $past(COUNTER_VALUE, 2) || $past(S_AXI_BVALID);
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("capture value wrong");
  // match c and capture flags fall only with a write-one-clear
  property p_cmp_clr;
    $fell(COMPARE_IRQ_C) |-> S_AXI_BVALID;
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("match flag lost");
  property p_cap_clr;
    $fell(CAPTURE_IRQ) |-> S_AXI_BVALID;
  endproperty
  a_cap_clr: assert property (p_cap_clr) else $error("capture flag lost");
endmodule
bind tccr_top tccr_chk chk_u (
  .SYS_CLK, .SRST, .COUNTER_VALUE, .COUNTER_TOP, .COMPARE_IRQ_C, .CAPTURE_IRQ,
  .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
  .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY
);
`default_nettype wire

/* File: tccr_pkg.sv */
// package: register map, field layout and mode codes for the timer compare/capture block
`default_nettype none
package tccr_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [7:0] TCCR_ADDR_CMP_A_LO  = 8'h00;
  localparam logic [7:0] TCCR_ADDR_CMP_A_HI  = 8'h04;
  localparam logic [7:0] TCCR_ADDR_CMP_C_LO  = 8'h08;
  localparam logic [7:0] TCCR_ADDR_CMP_C_HI  = 8'h0C;
  localparam logic [7:0] TCCR_ADDR_CAP_LO    = 8'h10;
  localparam logic [7:0] TCCR_ADDR_CAP_HI    = 8'h14;
  localparam logic [7:0] TCCR_ADDR_CTRL      = 8'h18;
  localparam logic [7:0] TCCR_ADDR_FLAGS     = 8'h1C;
  localparam logic [7:0] TCCR_ADDR_STROBE    = 8'h20;
  // control register fields
  localparam int TCCR_CTRL_MODE_LSB  = 0;  // waveform_mode_select[3:0]
  localparam int TCCR_CTRL_ACSEL_BIT = 4;  // capture source: comparator
  localparam int TCCR_CTRL_EDGE_BIT  = 5;  // capture on rising edge
  localparam int TCCR_CTRL_TGLA_BIT  = 6;  // toggle pin a on match
  localparam int TCCR_CTRL_TGLC_BIT  = 7;  // toggle pin c on match
  // flag register fields
  localparam int TCCR_FLAG_CAP_BIT   = 0;
  localparam int TCCR_FLAG_CMPA_BIT  = 1;
  localparam int TCCR_FLAG_CMPC_BIT  = 2;
  // strobe register fields
  localparam int TCCR_STB_FORCEA_BIT = 0;
  localparam int TCCR_STB_FORCEC_BIT = 1;
  // reset values
  localparam logic [15:0] TCCR_CMP_RESET  = 16'h0000;
  localparam logic [7:0]  TCCR_CTRL_RESET = 8'h00;
  // waveform modes in which the capture register defines top
  localparam logic [3:0] TCCR_MODE_CTC_CAP  = 4'hC;
  localparam logic [3:0] TCCR_MODE_PWM_CAP1 = 4'h8;
  localparam logic [3:0] TCCR_MODE_PWM_CAP2 = 4'hA;
  localparam logic [3:0] TCCR_MODE_PWM_CAP3 = 4'hE;
  // axi response codes
  localparam logic [1:0] TCCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TCCR_RESP_SLVERR = 2'h2;
  // write channel states
  typedef enum logic [2:0] {
    TCCR_W_IDLE = 3'b001,
    TCCR_W_WAIT = 3'b010,
    TCCR_W_RESP = 3'b100
  } tccr_wstate_e;
endpackage
`default_nettype wire

/* File: tccr_top.sv */
// timer compare/capture registers with shared high-byte latch, axi4-lite slave
`default_nettype none
module tccr_top
  import tccr_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic [15:0] COUNTER_VALUE,
  input  wire logic        CAPTURE_INPUT_PIN,
  input  wire logic        COMPARATOR_OUT,
  output logic      [15:0] COUNTER_TOP,
  output logic             TOP_FROM_CAPTURE,
  output logic             COMPARE_OUTPUT_PIN_A,
  output logic             COMPARE_OUTPUT_PIN_C,
  output logic             COMPARE_IRQ_A,
  output logic             COMPARE_IRQ_C,
  output logic             CAPTURE_IRQ,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // true when the mode makes the capture register the count limit
  function automatic logic cap_is_top(input logic [3:0] mode);
    cap_is_top = (mode == TCCR_MODE_CTC_CAP) || (mode == TCCR_MODE_PWM_CAP1) ||
                 (mode == TCCR_MODE_PWM_CAP2) || (mode == TCCR_MODE_PWM_CAP3);
  endfunction

  logic [15:0]  cmp_a;        // compare value a
  logic [15:0]  compare_value_c;  // compare value c
  logic [15:0]  cap;          // capture register
  logic [7:0]   hold_byte;    // shared high-byte latch
  logic [7:0]   ctrl;         // mode and source control
  logic [2:0]   flags;        // sticky event flags
  logic         trig_q;       // previous trigger level
  logic         eq_a_q;       // registered equality a
  logic         eq_c_q;       // registered equality c
  logic         top_q;        // registered top hit
  tccr_wstate_e wst;          // write channel state
  logic [7:0]   aw_addr;      // captured write address
  logic         aw_have;      // write address held
  logic [31:0]  w_data;       // captured write data
  logic [3:0]   w_strb;       // captured write strobes
  logic         w_have;       // write data held

  // capture trigger source and edge detect
  wire       trig_src  = ctrl[TCCR_CTRL_ACSEL_BIT] ? COMPARATOR_OUT : CAPTURE_INPUT_PIN;
  wire       trig_edge = ctrl[TCCR_CTRL_EDGE_BIT] ? (trig_src & ~trig_q) : (~trig_src & trig_q);
  wire [3:0] mode      = ctrl[TCCR_CTRL_MODE_LSB +: 4];
  wire       use_top   = cap_is_top(mode);
  // while capture is top the register is not overwritten by pin events
  wire       cap_load  = trig_edge & ~use_top;
  wire       eq_a      = (COUNTER_VALUE == cmp_a);
  wire       eq_c      = (COUNTER_VALUE == compare_value_c);
  wire       at_top    = use_top & (COUNTER_VALUE == cap);

  // write decode, only once address and data are both held
  wire       w_go      = aw_have & w_have & (wst == TCCR_W_WAIT);
  wire       w_lane0   = w_strb[0];
  wire       w_hi_a    = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CMP_A_HI);
  wire       w_hi_c    = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CMP_C_HI);
  wire       w_hi_cap  = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CAP_HI);
  wire       w_lo_a    = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CMP_A_LO);
  wire       w_lo_c    = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CMP_C_LO);
  wire       w_lo_cap  = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CAP_LO);
  wire       w_ctrl    = w_go & w_lane0 & (aw_addr == TCCR_ADDR_CTRL);
  wire       w_flags   = w_go & w_lane0 & (aw_addr == TCCR_ADDR_FLAGS);
  wire       w_strobe  = w_go & w_lane0 & (aw_addr == TCCR_ADDR_STROBE);
  wire       w_known   = (aw_addr <= TCCR_ADDR_STROBE) & (aw_addr[1:0] == 2'h0);
  wire [7:0] wb        = w_data[7:0];
  wire       force_a   = w_strobe & wb[TCCR_STB_FORCEA_BIT];
  wire       force_c   = w_strobe & wb[TCCR_STB_FORCEC_BIT];

  // read decode; low-byte reads also load the shared latch
  wire       r_go      = S_AXI_ARVALID & S_AXI_ARREADY;
  wire       r_lo_a    = r_go & (S_AXI_ARADDR == TCCR_ADDR_CMP_A_LO);
  wire       r_lo_c    = r_go & (S_AXI_ARADDR == TCCR_ADDR_CMP_C_LO);
  wire       r_lo_cap  = r_go & (S_AXI_ARADDR == TCCR_ADDR_CAP_LO);
  wire       r_hi      = (S_AXI_ARADDR == TCCR_ADDR_CMP_A_HI) | (S_AXI_ARADDR == TCCR_ADDR_CMP_C_HI) |
                         (S_AXI_ARADDR == TCCR_ADDR_CAP_HI);
  wire       r_known   = (S_AXI_ARADDR <= TCCR_ADDR_STROBE) & (S_AXI_ARADDR[1:0] == 2'h0);
  logic [7:0] r_byte;
  always_comb
  begin
    unique case (S_AXI_ARADDR)
      TCCR_ADDR_CMP_A_LO: r_byte = cmp_a[7:0];
      TCCR_ADDR_CMP_C_LO: r_byte = compare_value_c[7:0];
      TCCR_ADDR_CAP_LO:   r_byte = cap[7:0];
      TCCR_ADDR_CTRL:     r_byte = ctrl;
      TCCR_ADDR_FLAGS:    r_byte = {5'h00, flags};
      default:            r_byte = r_hi ? hold_byte : 8'h00;
    endcase
  end

  // flag next values: set wins over a write-one clear
  wire [2:0] clr       = w_flags ? wb[2:0] : 3'h0;
  wire       set_cap   = use_top ? top_q : cap_load;
  wire [2:0] set_f     = {eq_c_q, eq_a_q, set_cap};
  wire [2:0] next_flags = (flags & ~clr) | set_f;

  // shared high-byte latch: written by high writes, loaded by low reads
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      hold_byte <= 8'h00;
    else if (w_hi_a | w_hi_c | w_hi_cap)
      hold_byte <= wb;
    else if (r_lo_a)
      hold_byte <= cmp_a[15:8];
    else if (r_lo_c)
      hold_byte <= compare_value_c[15:8];
    else if (r_lo_cap)
      hold_byte <= cap[15:8];
  end

  // compare registers: the low write commits both bytes at once
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      cmp_a           <= TCCR_CMP_RESET;
      compare_value_c <= TCCR_CMP_RESET;
    end
    else
    begin
      if (w_lo_a)
        cmp_a <= {hold_byte, wb};
      if (w_lo_c)
        compare_value_c <= {hold_byte, wb};
    end
  end

  // capture register: trigger event when not top, or software write in any mode
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      cap <= TCCR_CMP_RESET;
    else if (cap_load)
      cap <= COUNTER_VALUE;
    else if (w_lo_cap)
      cap <= {hold_byte, wb};
  end

  // control, flags and event pipeline
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      ctrl   <= TCCR_CTRL_RESET;
      flags  <= 3'h0;
      trig_q <= 1'b0;
      eq_a_q <= 1'b0;
      eq_c_q <= 1'b0;
      top_q  <= 1'b0;
    end
    else
    begin
      if (w_ctrl)
        ctrl <= wb;
      flags  <= next_flags;
      trig_q <= trig_src;
      eq_a_q <= eq_a;
      eq_c_q <= eq_c;
      top_q  <= at_top;
    end
  end

  // output pins toggle on a match or on a forced strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      COMPARE_OUTPUT_PIN_A <= 1'b0;
      COMPARE_OUTPUT_PIN_C <= 1'b0;
    end
    else
    begin
      if (ctrl[TCCR_CTRL_TGLA_BIT] & (eq_a | force_a))
        COMPARE_OUTPUT_PIN_A <= ~COMPARE_OUTPUT_PIN_A;
      if (ctrl[TCCR_CTRL_TGLC_BIT] & (eq_c | force_c))
        COMPARE_OUTPUT_PIN_C <= ~COMPARE_OUTPUT_PIN_C;
    end
  end

  // registered request levels and top value
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      COMPARE_IRQ_A    <= 1'b0;
      COMPARE_IRQ_C    <= 1'b0;
      CAPTURE_IRQ      <= 1'b0;
      COUNTER_TOP      <= TCCR_CMP_RESET;
      TOP_FROM_CAPTURE <= 1'b0;
    end
    else
    begin
      COMPARE_IRQ_A    <= next_flags[TCCR_FLAG_CMPA_BIT];
      COMPARE_IRQ_C    <= next_flags[TCCR_FLAG_CMPC_BIT];
      CAPTURE_IRQ      <= next_flags[TCCR_FLAG_CAP_BIT];
      COUNTER_TOP      <= cap;
      TOP_FROM_CAPTURE <= use_top;
    end
  end

  // write channel: take address and data in either order
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      wst          <= TCCR_W_IDLE;
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= TCCR_RESP_OKAY;
    end
    else
    begin
      unique case (wst)
        TCCR_W_IDLE:
        begin
          S_AXI_AWREADY <= 1'b1;
          S_AXI_WREADY  <= 1'b1;
          wst           <= TCCR_W_WAIT;
        end
        TCCR_W_WAIT:
        begin
          if (S_AXI_AWVALID & S_AXI_AWREADY)
          begin
            aw_addr       <= S_AXI_AWADDR;
            aw_have       <= 1'b1;
            S_AXI_AWREADY <= 1'b0;
          end
          if (S_AXI_WVALID & S_AXI_WREADY)
          begin
            w_data       <= S_AXI_WDATA;
            w_strb       <= S_AXI_WSTRB;
            w_have       <= 1'b1;
            S_AXI_WREADY <= 1'b0;
          end
          if (w_go)
          begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= w_known ? TCCR_RESP_OKAY : TCCR_RESP_SLVERR;
            wst          <= TCCR_W_RESP;
          end
        end
        TCCR_W_RESP:
        begin
          if (S_AXI_BREADY)
          begin
            S_AXI_BVALID <= 1'b0;
            wst          <= TCCR_W_IDLE;
          end
        end
        default:
          wst <= TCCR_W_IDLE;
      endcase
    end
  end

  // read channel: one read at a time, answer the cycle after the address
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= TCCR_RESP_OKAY;
    end
    else if (r_go)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= {24'h000000, r_byte};
      S_AXI_RRESP   <= r_known ? TCCR_RESP_OKAY : TCCR_RESP_SLVERR;
    end
    else if (S_AXI_RVALID)
    begin
      if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
    else
      S_AXI_ARREADY <= 1'b1;
  end

endmodule
`default_nettype wire

/* File: testbench.sv */
// testbench: compare, capture, top and register bus scenarios
`default_nettype none
module testbench import tccr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus, idle at start
  logic        clk = 1'b0, rst = 1'b1, cpin = 1'b0, cmpo = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [15:0] cnt = 16'hFFFF;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'h1;
  // observed outputs
  logic [15:0] ctop;
  logic        tfc, pa, pc, ia, ic, icap, awrdy, wrdy, bvld, arrdy, rvld;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  int          fails = 0, checks_done = 0;
  tccr_top dut_u (
    .SYS_CLK(clk), .SRST(rst), .COUNTER_VALUE(cnt), .CAPTURE_INPUT_PIN(cpin), .COMPARATOR_OUT(cmpo),
    .COUNTER_TOP(ctop), .TOP_FROM_CAPTURE(tfc), .COMPARE_OUTPUT_PIN_A(pa), .COMPARE_OUTPUT_PIN_C(pc),
    .COMPARE_IRQ_A(ia), .COMPARE_IRQ_C(ic), .CAPTURE_IRQ(icap), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvld),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvld), .S_AXI_RREADY(rry)
  );
  initial forever #5 clk = ~clk;
  task give_verdict;
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // one counted comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // let edges pass, then look after updates land
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // lane-0 write; each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bit aw = 0, w = 0;
    @(posedge clk);
    {awa, awv, wd, wv, bry} <= {a, 1'b1, 24'h0, v, 2'b11};
    while (!(aw && w))
    begin
      @(posedge clk);
      if (awrdy) aw = 1;
      if (wrdy) w = 1;
      if (aw) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end
    while (!bvld) @(posedge clk);
    r = bresp;
    bry <= 1'b0;
  endtask
  // read; answer taken at the edge it is seen
  task rd(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rvld);
    {d, r} = {rdata, rresp};
    rry <= 1'b0;
  endtask
  // staged compare write, match one edge, flag the next
  task t_cmp;
    rd(TCCR_ADDR_CTRL);
    chk(d, 32'h0);
    wr(TCCR_ADDR_CTRL, 8'h80);
    wr(TCCR_ADDR_CMP_C_HI, 8'h12);
    wr(TCCR_ADDR_CMP_C_LO, 8'h34);
    rd(TCCR_ADDR_CMP_C_LO);
    chk(d, 32'h34);
    rd(TCCR_ADDR_CMP_C_HI);
    chk(d, 32'h12);
    @(posedge clk);
    cnt <= 16'h1233;
    @(posedge clk);
    cnt <= 16'h1234;
    @(posedge clk);
    cnt <= 16'h1235;
    #1;
    chk({pc, ic}, 2'b10);
    tick(1);
    chk(ic, 1'b1);
    wr(TCCR_ADDR_FLAGS, 8'h04);
    #1;
    chk(ic, 1'b0);
  endtask
  // one latch across compare a and c, unmapped place refused
  task t_latch;
    wr(TCCR_ADDR_CMP_A_HI, 8'hAB);
    wr(TCCR_ADDR_CMP_C_LO, 8'h56);
    chk(r, TCCR_RESP_OKAY);
    rd(TCCR_ADDR_CMP_C_HI);
    chk(d, 32'hAB);
    wr(8'h24, 8'h01);
    chk(r, TCCR_RESP_SLVERR);
    rd(8'h24);
    chk({r, d[29:0]}, {TCCR_RESP_SLVERR, 30'h0});
  endtask
  // pin capture; high byte frozen by the low-byte read
  task t_cap;
    wr(TCCR_ADDR_CTRL, 8'h20);
    @(posedge clk);
    {cnt, cpin} <= {16'h0F0E, 1'b1};
    tick(3);
    chk({icap, ctop}, {1'b1, 16'h0F0E});
    @(posedge clk);
    {cnt, cpin} <= {16'h1111, 1'b0};
    rd(TCCR_ADDR_CAP_LO);
    chk(d, 32'h0E);
    {cnt, cpin} <= {16'h2222, 1'b1};
    tick(3);
    rd(TCCR_ADDR_CAP_HI);
    chk(d, 32'h0F);
    chk(ctop, 16'h2222);
    wr(TCCR_ADDR_FLAGS, 8'h01);
    #1;
    chk(icap, 1'b0);
    wr(TCCR_ADDR_CTRL, 8'h30);
    {cnt, cmpo, cpin} <= {16'h3333, 2'b10};
    tick(3);
    @(posedge clk);
    {cnt, cpin} <= {16'h4444, 1'b1};
    tick(3);
    chk(ctop, 16'h3333);
  endtask
  // every top mode, then flag at top
  task automatic t_top;
    logic [3:0] m [4] = '{TCCR_MODE_PWM_CAP1, TCCR_MODE_PWM_CAP2, TCCR_MODE_PWM_CAP3, TCCR_MODE_CTC_CAP};
    foreach (m[i])
    begin
      wr(TCCR_ADDR_CTRL, {4'h0, m[i]});
      tick(2);
      chk(tfc, 1'b1);
    end
    wr(TCCR_ADDR_FLAGS, 8'h01);
    wr(TCCR_ADDR_CAP_HI, 8'h00);
    wr(TCCR_ADDR_CAP_LO, 8'h40);
    @(posedge clk);
    cnt <= 16'h0040;
    @(posedge clk);
    cnt <= 16'h0041;
    #1;
    chk({icap, ctop}, {1'b0, 16'h0040});
    tick(1);
    chk(icap, 1'b1);
    wr(TCCR_ADDR_CTRL, 8'h04);
    tick(2);
    chk(tfc, 1'b0);
  endtask
  // forced strobes toggle pins, set no flag
  task t_force;
    wr(TCCR_ADDR_CTRL, 8'hC0);
    wr(TCCR_ADDR_STROBE, 8'h03);
    tick(2);
    chk({pa, pc, ia, ic}, 4'b1000);
    // compare a: staged write, then a match toggles pin a back and raises its request
    wr(TCCR_ADDR_CMP_A_HI, 8'h00);
    wr(TCCR_ADDR_CMP_A_LO, 8'h50);
    rd(TCCR_ADDR_CMP_A_LO);
    chk(d, 32'h50);
    chk(r, TCCR_RESP_OKAY);
    @(posedge clk);
    cnt <= 16'h0050;
    @(posedge clk);
    cnt <= 16'h0051;
    #1;
    chk({pa, ia}, 2'b00);
    tick(1);
    chk(ia, 1'b1);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_cmp;
    t_latch;
    t_cap;
    t_top;
    t_force;
    give_verdict;
  end
  // hang guard, far beyond the whole sequence
  initial
  begin
    #50000;
    fails++;
    give_verdict;
  end
endmodule
`default_nettype wire
